/* verilog/sps_pkg.sv */
/*
  Shared definitions for the settings profile store: control register
  bit positions, result codes, state codes and the carriers that join
  the store to its non-volatile memory.
  Assumes a single system clock and a synchronous active-high reset.
*/
package sps_pkg;
  // Control word bit positions (big-endian bit 0 is the word's msb)
  localparam int unsigned PRESENT_BIT  = 31;   // Feature present
  localparam int unsigned ERROR_BIT    = 30;   // Error flag, bit [1]
  localparam int unsigned BUSY_BIT     = 24;   // Busy flag, bit [7]
  localparam int unsigned STORE_BIT    = 23;   // Store request, bit [8]
  localparam int unsigned RECALL_BIT   = 22;   // Recall request, bit [9]
  localparam int unsigned STARTUP_BIT  = 21;   // Mark startup, bit [10]
  localparam int unsigned CODE_LSB     = 8;    // Result code, bits [20..23]
  localparam int unsigned SLOT_LSB     = 0;    // Slot index, bits [28..31]

  // Result codes
  localparam logic [3:0] RC_OK        = 4'h0;
  localparam logic [3:0] RC_CORRUPT   = 4'h1;
  localparam logic [3:0] RC_NOT_IDLE  = 4'h2;
  localparam logic [3:0] RC_ABSENT    = 4'h3;
  localparam logic [3:0] RC_NO_SLOT   = 4'h4;
  localparam logic [3:0] RC_RANGE     = 4'h5;
  localparam logic [3:0] RC_STARTUP   = 4'h6;
  localparam logic [3:0] RC_LUT_LOAD  = 4'h7;
  localparam logic [3:0] RC_LUT_STORE = 4'h8;

  // Reset values
  localparam logic [3:0] SLOT_RST     = 4'h0;
  localparam logic [3:0] FACTORY_SLOT = 4'h0;

  // Controller states, one-hot
  typedef enum logic [4:0] {
    SPS_BOOT   = 5'b0_0001,
    SPS_IDLE   = 5'b0_0010,
    SPS_STORE  = 5'b0_0100,
    SPS_RECALL = 5'b0_1000,
    SPS_WAIT   = 5'b1_0000
  } sps_state_e;

  // Request to the non-volatile memory
  typedef struct packed {
    logic       req;        // One-cycle start pulse
    logic       write;      // 1 store, 0 read back
    logic       factory;    // Load hard-coded factory set
    logic       startup;    // Startup choice: record it, or load the chosen slot
    logic [3:0] slot;       // Profile number
  } sps_nvm_req_s;

  // Answer from the non-volatile memory
  typedef struct packed {
    logic       done;       // One-cycle completion pulse
    logic       exists;     // Slot has been stored before
    logic       corrupt;    // Checksum fault on read
    logic       lut_fail;   // Lookup-table part failed
    logic [3:0] startup;    // Stored startup choice
  } sps_nvm_rsp_s;
endpackage

/* verilog/sps_store.sv */
/*
  Settings profile store controller. One control word, written and read
  over a plain strobe port. Store and recall run atomically while the
  write acknowledge is withheld. Profile contents live in an external
  non-volatile memory reached by the request/answer carriers; that memory
  moves only the settings that belong to a profile, and on a factory
  request reloads every register from the hard-coded set.
  Assumes one system clock with a synchronous active-high reset. The host
  issues one write at a time and waits for its answer before the next.
  Writes that arrive while an operation runs are dropped with no answer.
  Reads are served at any time, their data one cycle later. The memory
  takes one request at a time and answers each with one done pulse, any
  number of cycles later, and keeps its slots across resets.
  Slot zero cannot be stored, and the reported slot changes only after a
  successful recall, a boot or a factory reload.
*/
// Local design decisions: the placing of the registers and the plain strobe port.
module sps_store #(
  parameter logic [3:0] SLOT_MAX = 4'h3,  // Highest valid profile
  parameter bit         PRESENT  = 1'b1   // Feature built in
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [31:0]         reg_wdata,
  output logic [31:0]              reg_rdata,
  output logic                     reg_wack,
  // Camera status and control
  input  wire logic                cam_idle,
  input  wire logic                init_cmd,
  output logic                     capture_off,
  // Non-volatile memory
  output sps_pkg::sps_nvm_req_s    nvm_req,
  input  wire sps_pkg::sps_nvm_rsp_s nvm_rsp
);

  // State registers
  sps_pkg::sps_state_e state_q, state_d;
  logic [3:0]  code_q,  code_d;        // Result code
  logic [3:0]  slot_q,  slot_d;        // Reported slot index
  logic        boot_q,  boot_d;        // Boot recall in progress
  logic        capoff_q, capoff_d;     // Capture disabled
  logic        ack_q,   ack_d;         // Write acknowledge
  logic [31:0] rdata_q, rdata_d;       // Read data
  sps_pkg::sps_nvm_req_s req_q, req_d; // Memory request

  // Flags of the incoming write
  logic       wr_store;                // Store request flag
  logic       wr_recall;               // Recall request flag
  logic       wr_mark;                 // Mark startup flag
  logic       wr_any;                  // Any request flag set
  logic [3:0] wr_slot;                 // Addressed profile
  // Status
  logic       busy;                    // Operation or boot running
  logic       wr_take;                 // Write accepted this cycle

  // Slot range check, used by every command
  function automatic logic slot_bad(input logic [3:0] s);
    return s > SLOT_MAX;
  endfunction

  // Any request flag in a control word; zero means clear-only write
  function automatic logic any_flag(input logic [31:0] w);
    return w[sps_pkg::STORE_BIT] | w[sps_pkg::RECALL_BIT] | w[sps_pkg::STARTUP_BIT];
  endfunction

  assign wr_store  = reg_wdata[sps_pkg::STORE_BIT];
  assign wr_recall = reg_wdata[sps_pkg::RECALL_BIT];
  assign wr_mark   = reg_wdata[sps_pkg::STARTUP_BIT];
  assign wr_slot   = reg_wdata[sps_pkg::SLOT_LSB +: 4];
  // Flagless writes only clear the code and the capture-off flag
  assign wr_any    = any_flag(reg_wdata);
  // Writes count only when nothing runs
  assign wr_take   = (state_q == sps_pkg::SPS_IDLE) && !init_cmd && reg_wr;
  assign busy = (state_q == sps_pkg::SPS_STORE) || (state_q == sps_pkg::SPS_RECALL)
             || (state_q == sps_pkg::SPS_BOOT) || (state_q == sps_pkg::SPS_WAIT);

  // Next state and register computation
  always_comb begin
    state_d  = state_q;
    code_d   = code_q;
    slot_d   = slot_q;
    boot_d   = boot_q;
    capoff_d = capoff_q;
    // Answers and memory pulses last one cycle
    ack_d    = 1'b0;
    req_d    = '0;
    // Slot held so a finished recall can report it
    req_d.slot = req_q.slot;
    unique case (state_q)
      sps_pkg::SPS_BOOT: begin
        // Ask the memory for the stored startup choice;
        // no write answer ever follows a boot recall
        req_d.req     = 1'b1;
        req_d.startup = 1'b1;
        boot_d        = 1'b1;
        state_d       = sps_pkg::SPS_RECALL;
      end

      // Accept writes only here; a write that arrives while
      // busy is dropped and gets no answer
      sps_pkg::SPS_IDLE: begin
        // Initialise wins over a write in the same cycle
        if (init_cmd) begin
          state_d = sps_pkg::SPS_BOOT;
        end else if (reg_wr) begin
          code_d = sps_pkg::RC_OK;
          ack_d  = 1'b1;
          if (!PRESENT && wr_any) begin
            code_d = sps_pkg::RC_ABSENT;
          end else if (wr_any && slot_bad(wr_slot)) begin
            code_d = sps_pkg::RC_RANGE;
          end else if (wr_store) begin
            if (wr_slot == sps_pkg::FACTORY_SLOT) begin
              code_d = sps_pkg::RC_RANGE;
            end else begin
              capoff_d    = 1'b1;
              ack_d       = 1'b0;
              req_d.req   = 1'b1;
              req_d.write = 1'b1;
              req_d.slot  = wr_slot;
              state_d     = sps_pkg::SPS_STORE;
            end
          end else if (wr_recall) begin
            if (!cam_idle) begin
              code_d = sps_pkg::RC_NOT_IDLE;
            end else begin
              ack_d      = 1'b0;
              req_d.req  = 1'b1;
              req_d.slot = wr_slot;
              state_d    = sps_pkg::SPS_RECALL;
            end
          end else if (wr_mark) begin
            // Record startup choice
            // A slot never stored is accepted; it fails at boot
            ack_d         = 1'b0;
            req_d.req     = 1'b1;
            req_d.write   = 1'b1;
            req_d.startup = 1'b1;
            req_d.slot    = wr_slot;
            state_d       = sps_pkg::SPS_STORE;
          end
        end
      end

      // Memory saves window and advanced set, or records the startup choice
      sps_pkg::SPS_STORE: begin
        if (nvm_rsp.done) begin
          if (nvm_rsp.lut_fail) begin
            code_d = sps_pkg::RC_LUT_STORE;
          end
          // Answer the held write now
          ack_d   = 1'b1;
          state_d = sps_pkg::SPS_IDLE;
        end
      end

      sps_pkg::SPS_RECALL: begin
        if (nvm_rsp.done) begin
          if (!nvm_rsp.exists || nvm_rsp.corrupt || nvm_rsp.lut_fail) begin
            if (nvm_rsp.corrupt) begin
              code_d = sps_pkg::RC_CORRUPT;
            end else if (nvm_rsp.lut_fail) begin
              code_d = sps_pkg::RC_LUT_LOAD;
            end else begin
              code_d = sps_pkg::RC_NO_SLOT;
            end
            if (boot_q) begin
              code_d = sps_pkg::RC_STARTUP;
            end
            // Fall back to factory set
            // The held write is answered after the reload
            req_d.req     = 1'b1;
            req_d.factory = 1'b1;
            req_d.slot    = sps_pkg::FACTORY_SLOT;
            state_d       = sps_pkg::SPS_WAIT;
          end else begin
            // Report loaded slot; a boot answer carries
            // the startup choice that the memory applied
            slot_d  = boot_q ? nvm_rsp.startup : req_q.slot;
            // Answer the held write unless this was boot
            ack_d   = !boot_q;
            boot_d  = 1'b0;
            state_d = sps_pkg::SPS_IDLE;
          end
        end
      end

      // Factory reload in progress
      sps_pkg::SPS_WAIT: begin
        if (nvm_rsp.done) begin
          // Factory set loaded, report slot zero
          slot_d  = sps_pkg::FACTORY_SLOT;
          ack_d   = !boot_q;
          boot_d  = 1'b0;
          state_d = sps_pkg::SPS_IDLE;
        end
      end
      default: begin
        // Illegal one-hot code: recover to idle
        state_d = sps_pkg::SPS_IDLE;
      end
    endcase
    // Capture stays off until a later accepted write
    // that is not itself a store; writes dropped while busy
    // or beside an initialise command leave it alone
    if (wr_take && !wr_store) begin
      capoff_d = 1'b0;
    end
  end

  // Read data: status and fields
  // Zero outside the answer cycle so a stale word never lingers
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      // Reads are served even while busy, so the host can poll
      rdata_d[sps_pkg::PRESENT_BIT]     = PRESENT;
      rdata_d[sps_pkg::ERROR_BIT]       = (code_q != sps_pkg::RC_OK);
      rdata_d[sps_pkg::BUSY_BIT]        = busy;
      rdata_d[sps_pkg::CODE_LSB +: 4]   = code_q;
      rdata_d[sps_pkg::SLOT_LSB +: 4]   = slot_q;
    end
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Reset lands in boot so the startup profile loads first
      state_q  <= sps_pkg::SPS_BOOT;
      code_q   <= sps_pkg::RC_OK;
      slot_q   <= sps_pkg::SLOT_RST;
      boot_q   <= 1'b0;
      capoff_q <= 1'b0;
      ack_q    <= 1'b0;
      rdata_q  <= '0;
      req_q    <= '0;
    end else begin
      // Take the next values
      state_q  <= state_d;
      code_q   <= code_d;
      slot_q   <= slot_d;
      boot_q   <= boot_d;
      capoff_q <= capoff_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      req_q    <= req_d;
    end
  end

  // Outputs
  // All come straight from flip-flops, so the host sees no glitch
  assign reg_rdata   = rdata_q;
  assign reg_wack    = ack_q;
  assign capture_off = capoff_q;
  assign nvm_req     = req_q;

endmodule

/* tb/sps_store_assertions.sv */
/* Port checker for the profile store.
   Assumes the memory answers one request at a time. */
module sps_store_checker (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  // Register port
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_wdata,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  reg_wack,
  // Camera side
  input wire logic                  cam_idle,
  input wire logic                  init_cmd,
  input wire logic                  capture_off,
  // Memory link
  input wire sps_pkg::sps_nvm_req_s nvm_req,
  input wire sps_pkg::sps_nvm_rsp_s nvm_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pend_q, pend_d, boot_q, boot_d; // Open request, boot
  sps_pkg::sps_nvm_req_s last_q, last_d;                 // Last request
  wire                   ready = !pend_q && !boot_q;     // Writes taken
  // Follow memory traffic
  always_comb begin
    pend_d = nvm_req.req || (pend_q && !nvm_rsp.done);
    boot_d = boot_q && !nvm_rsp.done;
    last_d = nvm_req.req ? nvm_req : last_q;
  end
  always_ff @(posedge clk_sys) begin
    pend_q <= !sys_rst && pend_d;
    boot_q <= sys_rst || boot_d;
    last_q <= sys_rst ? '0 : last_d;
  end
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Recall answered as missing or corrupt
  sequence s_recall_bad;
    nvm_rsp.done && pend_q && !last_q.write && !last_q.factory && !last_q.startup
      && (!nvm_rsp.exists || nvm_rsp.corrupt);
  endsequence
  // Factory set requested
  sequence s_factory;
    nvm_req.req && nvm_req.factory && nvm_req.slot == sps_pkg::FACTORY_SLOT;
  endsequence
  a_error_flag: assert property (reg_rd |=> reg_rdata[30] == (reg_rdata[11:8] != 4'h0))
    else $error("error flag disagrees with code");
  a_store_capoff: assert property (nvm_req.req && nvm_req.write && !nvm_req.startup |-> capture_off)
    else $error("store with capture on");
  a_wack_held: assert property (pend_q && !nvm_rsp.done |-> !reg_wack)
    else $error("answer before completion");
  a_atomic_op: assert property (pend_q && !nvm_rsp.done |-> !nvm_req.req)
    else $error("second request while one open");
  a_slot0_store: assert property (reg_wr && ready && reg_wdata[23:21] == 3'b100
    && reg_wdata[3:0] == 4'h0 |=> reg_wack && !nvm_req.req)
    else $error("store to factory slot started");
  a_no_flag: assert property (reg_wr && ready && reg_wdata[23:21] == 3'b000
    |=> reg_wack && !nvm_req.req)
    else $error("flagless write misbehaved");
  a_not_idle: assert property (reg_wr && ready && reg_wdata[23:21] == 3'b010 && !cam_idle
    |=> reg_wack && !nvm_req.req)
    else $error("recall started while camera busy");
  a_recall_fail: assert property (s_recall_bad |=> s_factory)
    else $error("failed recall without factory load");
endmodule

/* tb/sps_nvm_model.sv */
/* Behavioural profile memory facing the store.
   Keeps slots across resets; bench sets delay and corrupt reads. */
module sps_nvm_model (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // Bench controls
  input  wire logic                  slow,
  input  wire logic                  bad_data,
  input  wire logic                  lut_bad,
  // Memory link
  input  wire sps_pkg::sps_nvm_req_s nvm_req,
  output sps_pkg::sps_nvm_rsp_s      nvm_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0]           saved = 16'h0001; // Slots stored
  logic [3:0]            boot_slot = 4'h0; // Startup choice
  logic [5:0]            wait_cnt;         // Cycles to answer
  sps_pkg::sps_nvm_req_s cur;              // Request in work
  wire  [3:0]            tgt = cur.startup ? boot_slot : cur.slot;
  initial nvm_rsp = '0;
  // Answer one request; idle fields scramble
  always @(posedge clk_sys) begin
    nvm_rsp <= {1'b0, ~nvm_rsp[6:0]};
    if (sys_rst) begin
      wait_cnt <= '0;
    end else if (nvm_req.req) begin
      cur <= nvm_req;
      wait_cnt <= slow ? 6'h28 : 6'h01;
    end else if (wait_cnt > 6'h01) begin
      wait_cnt <= wait_cnt - 6'h01;
    end else if (wait_cnt == 6'h01) begin
      wait_cnt <= '0;
      nvm_rsp <= {1'b1, cur.factory | saved[tgt],
                  bad_data & !cur.write & !cur.factory,
                  lut_bad & !cur.factory, boot_slot};
      if (cur.write && cur.startup) boot_slot <= cur.slot;
      else if (cur.write) saved[cur.slot] <= 1'b1;
    end
  end
endmodule

/* tb/testbench.sv */
/* Self-checking bench for the profile store.
   Drives the register port; the memory model answers requests. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys = 1'b0, sys_rst = 1'b1;  // Clock, reset
  logic                  reg_wr = 1'b0, reg_rd = 1'b0;     // Strobes
  logic                  cam_idle = 1'b1, init_cmd = 1'b0; // Camera
  logic                  slow = 1'b0, bad_data = 1'b0;     // Model modes
  logic                  lut_bad = 1'b0;                   // Table fault
  logic [31:0]           reg_wdata = '0, reg_rdata, word;  // Data
  logic                  reg_wack, capture_off;            // Answers
  sps_pkg::sps_nvm_req_s nvm_req;                          // To memory
  sps_pkg::sps_nvm_rsp_s nvm_rsp;                          // From memory
  int                    errors = 0, samples_checked = 0, cyc = 0, n;
  always #12.5 clk_sys = ~clk_sys;
  sps_store #(.SLOT_MAX(4'h3), .PRESENT(1'b1)) u_dut (.clk_sys, .sys_rst, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_wack, .cam_idle, .init_cmd, .capture_off,
    .nvm_req, .nvm_rsp);
  sps_nvm_model u_nvm (.clk_sys, .sys_rst, .slow, .bad_data, .lut_bad, .nvm_req,
    .nvm_rsp);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] cw(logic [2:0] f, logic [3:0] s);
    return {8'h00, f, 17'h0_0000, s};
  endfunction
  // One write, then wait for its answer
  task automatic wr(logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    for (n = 0; n < 200 && reg_wack !== 1'b1; n++) @(negedge clk_sys);
    check("write answer", reg_wack, 1'b1);
  endtask
  task automatic rd();
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    word = reg_rdata;
  endtask
  task automatic code(logic [3:0] c);
    for (int i = 0; i < 200 && (i == 0 || word[24] !== 1'b0); i++) rd();
    check("result code", word[11:8], c);
    check("error flag", word[30], c != 4'h0);
  endtask
  task automatic t_rst();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic t_store();
    slow <= 1'b1;
    wr(cw(3'b100, 4'h2));
    check("held answer", n >= 40, 1'b1);
    check("capture off", capture_off, 1'b1);
    code(4'h0);
    wr(cw(3'b010, 4'h2));
    code(4'h0);
    check("slot index", word[3:0], 4'h2);
    check("capture back on", capture_off, 1'b0);
    slow <= 1'b0;
    bad_data <= 1'b1;
    wr(cw(3'b010, 4'h2));
    code(4'h1);
    bad_data <= 1'b0;
    lut_bad <= 1'b1;
    wr(cw(3'b100, 4'h2));
    code(4'h8);
    wr(cw(3'b010, 4'h2));
    code(4'h7);
    check("slot after bad load", word[3:0], 4'h0);
    lut_bad <= 1'b0;
    $display("store and recall test done");
  endtask
  task automatic t_codes();
    logic [2:0] f [5] = '{3'b100, 3'b010, 3'b010, 3'b001, 3'b010};
    logic [3:0] s [5] = '{4'h0, 4'h5, 4'h3, 4'h9, 4'h2};
    logic [3:0] c [5] = '{4'h5, 4'h5, 4'h4, 4'h5, 4'h2};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      cam_idle <= (i != 4);
      wr(cw(f[i], s[i]));
      code(c[i]);
      wr(i[0] ? 32'h0000_0000 : cw(3'b000, 4'h3));
      code(4'h0);
    end
    @(posedge clk_sys);
    cam_idle <= 1'b1;
    $display("result code test done");
  endtask
  task automatic t_startup();
    wr(cw(3'b001, 4'h2));
    code(4'h0);
    @(posedge clk_sys);
    init_cmd <= 1'b1;
    @(posedge clk_sys);
    init_cmd <= 1'b0;
    code(4'h0);
    check("slot after init", word[3:0], 4'h2);
    t_rst();
    code(4'h0);
    check("slot after reset", word[3:0], 4'h2);
    wr(cw(3'b001, 4'h3));
    code(4'h0);
    @(posedge clk_sys);
    init_cmd <= 1'b1;
    @(posedge clk_sys);
    init_cmd <= 1'b0;
    code(4'h6);
    check("slot after bad boot", word[3:0], 4'h0);
    $display("startup test done");
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    t_rst();
    code(4'h0);
    check("boot slot", word[3:0], 4'h0);
    t_store();
    t_codes();
    t_startup();
    results();
  end
endmodule
bind sps_store sps_store_checker u_chk (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .reg_wack, .cam_idle, .init_cmd, .capture_off, .nvm_req, .nvm_rsp);
